// ### sim/acc_asserts.sv
`timescale 1ns/1ns
module acc_asserts
  import acc_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // link
  input logic frame_valid,
  input logic frame_ext,
  input logic [28:0] frame_id,
  input logic [3:0] frame_dlc,
  input logic [63:0] frame_data,
  input logic frame_ready,
  // converter results
  input logic cmd_taken,
  input logic cmd_dropped,
  input logic running,
  input logic [15:0] vdc_ref
);
  import acc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire take = frame_valid && frame_ready;
  AST_EXT: assert property (frame_valid |-> frame_ext)
    else $error("frame not extended");
  AST_DLC: assert property (frame_valid |-> frame_dlc == ACC_DLC)
    else $error("frame length not eight");
  AST_ID: assert property (frame_valid |-> frame_id == ACC_CMD_ID)
    else $error("wrong frame identifier");
  AST_RSV: assert property (frame_valid |-> frame_data[47:32] == ACC_RESERVED)
    else $error("reserved bytes not all ones");
  AST_HOLD: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("frame dropped or changed before take");
  AST_GAP: assert property (take |=> !frame_ready)
    else $error("ready not lowered after take");
  AST_ANS: assert property (take |=> cmd_taken != cmd_dropped)
    else $error("no single outcome after take");
  AST_IDLE: assert property (!take |=> !cmd_taken && !cmd_dropped)
    else $error("outcome without a take");
  AST_OFF: assert property (take && frame_data[55:48] != ACC_ONOFF_ON |=> cmd_taken && !running)
    else $error("off request did not stop");
  AST_VREF: assert property (take ##1 cmd_taken |-> vdc_ref == $past(frame_data[31:16]))
    else $error("voltage reference not stored");
endmodule : acc_asserts

// ### sim/acc_can_control_command_tb.sv
`timescale 1ns/1ns
module acc_can_control_command_tb;
  import acc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [7:0] cfg_mode = 8'h01, active_mode;
  logic [15:0] meas_vdc = 16'h1964, meas_iac_rms = 0, vdc_ref, idc_ref;
  logic awready, wready, bvalid, arready, rvalid, running, cmd_taken, cmd_dropped, ov, uv, oc;
  logic [1:0] rresp, bresp, last_bresp;
  int mismatches = 0, checks_done = 0;
  acc_link_if link();
  always #5 aclk = ~aclk;
  acc_controller i_acc_controller(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  acc_converter i_acc_converter(.aclk(aclk), .aresetn(aresetn), .link(link), .cfg_mode(cfg_mode),
    .meas_vdc(meas_vdc), .meas_iac_rms(meas_iac_rms), .running(running), .active_mode(active_mode),
    .vdc_ref(vdc_ref), .idc_ref(idc_ref), .cmd_taken(cmd_taken), .cmd_dropped(cmd_dropped),
    .dc_overvoltage_fault(ov), .dc_undervoltage_fault(uv), .line_overcurrent_fault(oc));
  acc_asserts i_acc_asserts(.aclk(aclk), .aresetn(aresetn), .frame_valid(link.frame_valid),
    .frame_ext(link.frame_ext), .frame_id(link.frame_id), .frame_dlc(link.frame_dlc),
    .frame_data(link.frame_data), .frame_ready(link.frame_ready), .cmd_taken(cmd_taken),
    .cmd_dropped(cmd_dropped), .running(running), .vdc_ref(vdc_ref));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // each task starts one edge on, so no signal is set twice in a step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic snd(input logic [31:0] c, input logic e);
    int n = 0;
    wr(ACC_REG_CTRL, c);
    do begin
      @(posedge aclk);
      n++;
    end while (!(cmd_taken || cmd_dropped) && n < 50);
    chk("outcome", {30'h0, e, ~e}, {30'h0, cmd_taken, cmd_dropped});
  endtask : snd
  task automatic flt(input logic [15:0] v, input logic [15:0] i, input logic [2:0] e);
    @(posedge aclk);
    meas_vdc <= v;
    meas_iac_rms <= i;
    repeat (3) @(posedge aclk);
    chk("faults", {29'h0, e}, {29'h0, ov, uv, oc});
  endtask : flt
  initial begin
    #50000;
    mismatches++;
    stop_test;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ACC_REG_CTRL, d, r);
    chk("ctrl_reset", 32'h200, d);
    rd(4'hC, d, r);
    chk("rresp", {30'h0, ACC_RESP_SLVERR}, {30'h0, r});
    wr(4'hC, 32'h00000000);
    chk("bresp_bad", {30'h0, ACC_RESP_SLVERR}, {30'h0, last_bresp});
    wr(ACC_REG_REFS, 32'h19640168);
    chk("bresp", {30'h0, ACC_RESP_OKAY}, {30'h0, last_bresp});
    rd(ACC_REG_REFS, d, r);
    chk("refs", 32'h19640168, d);
    snd(32'h101, 1'b1);
    rd(ACC_REG_STAT, d, r);
    chk("stat", 32'h2, d);
    chk("running", 32'h1, {31'h0, running});
    chk("mode", 32'h01, {24'h0, active_mode});
    chk("vref", 32'h1964, {16'h0, vdc_ref});
    chk("iref", 32'h0168, {16'h0, idc_ref});
    flt(16'h1964, 16'h0140, 3'b001);
    flt(16'h251D, 16'h013F, 3'b100);
    flt(16'h251C, 16'h0000, 3'b000);
    flt(16'h0E73, 16'h0000, 3'b010);
    flt(16'h0E74, 16'h0000, 3'b000);
    cfg_mode <= 8'h02;
    snd(32'h102, 1'b0);
    chk("mode_kept", 32'h01, {24'h0, active_mode});
    snd(32'h302, 1'b1);
    chk("stopped", 32'h0, {31'h0, running});
    snd(32'h102, 1'b1);
    chk("mode_new", 32'h02, {24'h0, active_mode});
    flt(16'h1964, 16'h0140, 3'b000);
    snd(32'h302, 1'b1);
    flt(16'h1964, 16'h0140, 3'b000);
    cfg_mode <= 8'h01;
    wr(ACC_REG_REFS, 32'h12340000);
    snd(32'h102, 1'b0);
    chk("vref_kept", 32'h1964, {16'h0, vdc_ref});
    chk("iref_kept", 32'h0168, {16'h0, idc_ref});
    chk("stay_off", 32'h0, {31'h0, running});
    stop_test;
  end
endmodule : acc_can_control_command_tb

// ### verilog/acc_controller.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module acc_controller
  import acc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // command link
  acc_link_if.controller link
);
  import acc_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] refs;
  logic [3:0] aw_q;
  logic aw_have;
  logic [31:0] w_q;
  logic w_have;
  logic sent_count_lsb;
  logic send_pend;
  logic [63:0] data_q;
  logic valid_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_q == ACC_REG_CTRL);
  wire wr_refs = do_write && (aw_q == ACC_REG_REFS);
  wire wr_ok = wr_ctrl || wr_refs;
  // ctrl bit 8 requests a send
  wire send_req = wr_ctrl && w_q[ACC_CTRL_SEND_BIT];
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] stat = {30'h00000000, sent_count_lsb, send_pend};
  wire rd_hit = (s_axi_araddr == ACC_REG_CTRL) || (s_axi_araddr == ACC_REG_REFS)
    || (s_axi_araddr == ACC_REG_STAT);
  wire [31:0] rd_val = (s_axi_araddr == ACC_REG_CTRL) ? ctrl :
    (s_axi_araddr == ACC_REG_REFS) ? refs :
    (s_axi_araddr == ACC_REG_STAT) ? stat : 32'h00000000;
  // [R2] [R4] big-endian payload with reserved ffff
  // taken from the write word: ctrl itself updates on the same edge that latches the payload
  wire [63:0] payload = {w_q[7:0], 7'h00, w_q[ACC_CTRL_OFF_BIT], ACC_RESERVED, refs[31:16], refs[15:0]};
  wire link_done = valid_q && link.frame_ready;

  // [R1] [R3] extended frame with fixed command id
  assign link.frame_ext = 1'b1;
  assign link.frame_id = ACC_CMD_ID;
  assign link.frame_dlc = ACC_DLC;
  assign link.frame_valid = valid_q;
  assign link.frame_data = data_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ACC_CTRL_RESET;
      refs <= 32'h00000000;
      aw_q <= 4'h0;
      aw_have <= 1'b0;
      w_q <= 32'h00000000;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ACC_RESP_OKAY;
      sent_count_lsb <= 1'b0;
      send_pend <= 1'b0;
      data_q <= 64'h0000000000000000;
      valid_q <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_have && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_q <= s_axi_awaddr;
        aw_have <= 1'b1;
      end
      if (w_take) begin
        w_q <= s_axi_wdata;
        w_have <= 1'b1;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= {22'h000000, w_q[ACC_CTRL_OFF_BIT], 1'b0, w_q[7:0]};
      end
      if (wr_refs) begin
        refs <= w_q;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (send_req && !valid_q) begin
        data_q <= payload;
        valid_q <= 1'b1;
        send_pend <= 1'b1;
      end else if (link_done) begin
        valid_q <= 1'b0;
        send_pend <= 1'b0;
        sent_count_lsb <= !sent_count_lsb;
      end
    end
  end
endmodule : acc_controller

// ### verilog/acc_converter.sv
// Summary of operation
// [R1] frames are extended 29-bit at 250 kbit/s
// [R2] eight data bytes, most significant first
// [R3] identifier 0x18A5E5F4 carries control command
// [R4] byte0 mode, byte1 on/off, bytes2-3 reserved
// [R5] mode 0x01 means three-phase charging
// [R6] bytes 4-5 voltage reference, 0.1 V
// [R7] bytes 6-7 current reference, 0.1 A
// [R8] current reference never limits current
// [R9] on with wrong mode discards command
// [R10] dc fault above 950 V or below 370 V
// [R11] charging line fault at 32 A RMS
// [R12] mode changes only accepted while off; an accepted off request still loads its mode into active_mode while running
// [R13] nonzero on/off byte stops the converter
// [R14] other id or length ignored
`timescale 1ns/1ns
module acc_converter
  import acc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command link
  acc_link_if.converter link,
  // configuration and measurements
  input wire logic [7:0] cfg_mode,
  input wire logic [15:0] meas_vdc,
  input wire logic [15:0] meas_iac_rms,
  // decoded command
  output logic running,
  output logic [7:0] active_mode,
  output logic [15:0] vdc_ref,
  output logic [15:0] idc_ref,
  output logic cmd_taken,
  output logic cmd_dropped,
  // protection
  output logic dc_overvoltage_fault,
  output logic dc_undervoltage_fault,
  output logic line_overcurrent_fault
);
  import acc_pkg::*;

  logic ready_q;
  // [R1] [R3] [R14] identity and length screen
  wire take = link.frame_valid && ready_q;
  wire frame_ok = link.frame_ext && (link.frame_id == ACC_CMD_ID) && (link.frame_dlc == ACC_DLC);
  // [R2] [R4] big-endian field extraction
  wire [7:0] rx_mode = link.frame_data[ACC_MODE_MSB -: 8];
  wire [7:0] rx_onoff = link.frame_data[ACC_ONOFF_MSB -: 8];
  wire [15:0] rx_vref = link.frame_data[ACC_VREF_MSB -: 16];
  wire [15:0] rx_iref = link.frame_data[ACC_IREF_MSB -: 16];
  wire rx_on = (rx_onoff == ACC_ONOFF_ON);
  // [R9] on request must match configured mode
  wire mode_bad = rx_on && (rx_mode != cfg_mode);
  // [R12] running converter refuses an on request with another mode
  wire mode_locked = rx_on && running && (rx_mode != active_mode);
  wire accept = take && frame_ok && !mode_bad && !mode_locked;
  // [R5] charging decode gates line protection
  wire charging = running && (active_mode == ACC_MODE_CHG_3PH);

  assign link.frame_ready = ready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_q <= 1'b0;
      running <= 1'b0;
      active_mode <= 8'h00;
      vdc_ref <= 16'h0000;
      idc_ref <= 16'h0000;
      cmd_taken <= 1'b0;
      cmd_dropped <= 1'b0;
      dc_overvoltage_fault <= 1'b0;
      dc_undervoltage_fault <= 1'b0;
      line_overcurrent_fault <= 1'b0;
    end else begin
      // one frame per two cycles keeps decode simple
      ready_q <= !take;
      cmd_taken <= accept;
      cmd_dropped <= take && !accept;
      if (accept) begin
        // [R13] nonzero byte1 is off whatever the mode
        running <= rx_on;
        active_mode <= rx_mode;
        // [R6] voltage reference stored
        vdc_ref <= rx_vref;
        // [R7] [R8] stored for report only, no limiter
        idc_ref <= rx_iref;
      end
      // [R10] dc bus window
      dc_overvoltage_fault <= (meas_vdc > ACC_VDC_MAX);
      dc_undervoltage_fault <= (meas_vdc < ACC_VDC_MIN);
      // [R11] line current limit while charging
      line_overcurrent_fault <= charging && (meas_iac_rms >= ACC_IAC_MAX);
    end
  end
endmodule : acc_converter

// ### verilog/acc_link_if.sv
`timescale 1ns/1ns
interface acc_link_if;
  logic frame_valid;
  logic frame_ext;
  logic [28:0] frame_id;
  logic [3:0] frame_dlc;
  logic [63:0] frame_data;
  logic frame_ready;
  modport controller (output frame_valid, output frame_ext, output frame_id, output frame_dlc,
    output frame_data, input frame_ready);
  modport converter (input frame_valid, input frame_ext, input frame_id, input frame_dlc,
    input frame_data, output frame_ready);
endinterface : acc_link_if

// ### verilog/acc_pkg.sv
package acc_pkg;
  // frame identity and length
  localparam logic [28:0] ACC_CMD_ID = 29'h18A5E5F4;
  localparam logic [3:0] ACC_DLC = 4'h8;
  // mode codes and on/off byte
  localparam logic [7:0] ACC_MODE_CHG_3PH = 8'h01;
  localparam logic [7:0] ACC_ONOFF_ON = 8'h00;
  localparam logic [15:0] ACC_RESERVED = 16'hFFFF;
  // payload byte positions, byte 0 in the top lane
  localparam int ACC_MODE_MSB = 63;
  localparam int ACC_ONOFF_MSB = 55;
  localparam int ACC_RSV_MSB = 47;
  localparam int ACC_VREF_MSB = 31;
  localparam int ACC_IREF_MSB = 15;
  // protection limits in 0.1 units
  localparam logic [15:0] ACC_VDC_MAX = 16'h251C;
  localparam logic [15:0] ACC_VDC_MIN = 16'h0E74;
  localparam logic [15:0] ACC_IAC_MAX = 16'h0140;
  // link bit rate and derived cycles at 100 MHz
  localparam int ACC_CLK_HZ = 100000000;
  localparam int ACC_BIT_RATE = 250000;
  localparam int ACC_BIT_CYC = ACC_CLK_HZ / ACC_BIT_RATE;
  // software register offsets of the sender
  localparam logic [3:0] ACC_REG_CTRL = 4'h0;
  localparam logic [3:0] ACC_REG_REFS = 4'h4;
  localparam logic [3:0] ACC_REG_STAT = 4'h8;
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
  // sender control word: send strobe, off request, reset value
  localparam int ACC_CTRL_SEND_BIT = 8;
  localparam int ACC_CTRL_OFF_BIT = 9;
  localparam logic [31:0] ACC_CTRL_RESET = 32'h00000200;
endpackage : acc_pkg
